// File: shared/prs_pkg.sv
// Constants and types for the pulse rate and stopwatch measurement core
// Behaviour
// - Rate modes measure input A, ignore B
// - Scale rate so reference frequency shows setpoint
// - No pulse within wait time: display zero
// - Wait time zero never times out
// - Filter off or average of 2/4/8/16
// - Processing time is reciprocal, formatted, auto point
// - Rate decimal point user placed, value unchanged
// - Stopwatch resolution selectable, seven time bases
// - Gated start counts while A is high
// - Start/stop: A rise starts, B rise stops
// - Period option shows time between A rises
// - No auto-restart: accumulate, external reset clears
// - Auto-restart clears count at every start
// - No latch: display tracks running count, except in period mode
// - Latch: hold result at stop, count continues in start/stop
// - Inputs active high, act on rising edges; the A fall also ends a gated count
// - Accept input rates up to 25 kHz
// - Menu in use suspends all measurement
package prs_pkg;

    localparam int CLK_HZ = 100_000_000;
    localparam int CLK_KHZ = CLK_HZ / 1000;
    localparam int RESET_MIN_US = 500;
    localparam int RESET_MIN_CYC = (RESET_MIN_US * CLK_KHZ + 999) / 1000;
    localparam int MS_CYC = CLK_HZ / 1000;
    localparam int SEC_CYC = CLK_HZ;
    localparam int MAX_RATE_HZ = 25_000;
    localparam int MIN_PERIOD_CYC = CLK_HZ / MAX_RATE_HZ;
    localparam int REF_MIN_HZ = 1;
    localparam int REF_MAX_HZ = 25_000;
    localparam int DIV_W = 64;
    localparam int DIV_STEPS = DIV_W;
    localparam int PER_W = 28;
    localparam int SEC_PER_MIN = 60;
    localparam int MMSS_SCALE = 100;
    localparam logic [12:0] UNIT_MS_1MS = 13'h0001;
    localparam logic [12:0] UNIT_MS_10MS = 13'h000a;
    localparam logic [12:0] UNIT_MS_100MS = 13'h0064;
    localparam logic [12:0] UNIT_MS_SEC = 13'h03e8;
    localparam logic [12:0] UNIT_MS_CMIN = 13'h0258;
    localparam logic [12:0] UNIT_MS_DMIN = 13'h1770;

    typedef enum logic [1:0] {PRS_RATE_DISPLAY_MODE, PRS_PROC_TIME, PRS_STOPWATCH} prs_mode_t;
    typedef enum logic [1:0] {PRS_GATED, PRS_START_STOP, PRS_PERIOD_MEASURE} prs_start_t;
    typedef enum logic [2:0] {
        PRS_BASE_MS, PRS_BASE_10MS, PRS_BASE_100MS, PRS_BASE_SEC,
        PRS_BASE_CMIN, PRS_BASE_DMIN, PRS_BASE_MIN_SEC
    } prs_base_t;
    typedef enum logic [1:0] {PRS_FMT_SEC, PRS_FMT_MIN, PRS_FMT_MIN_SEC, PRS_FMT_CMIN} prs_fmt_t;
    typedef enum logic [2:0] {PRS_FILT_OFF, PRS_FILT_2, PRS_FILT_4, PRS_FILT_8, PRS_FILT_16} prs_filt_t;

endpackage : prs_pkg

// File: logic/prs_core.sv
// Pulse rate, processing time and stopwatch measurement core
`timescale 1ns/1ps
module prs_core #(
    parameter int RESET_MIN_CYCLES = prs_pkg::RESET_MIN_CYC,
    parameter int MS_CYCLES = prs_pkg::MS_CYC,
    parameter int SEC_CYCLES = prs_pkg::SEC_CYC
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Pins from the sensors
    input wire logic in_a,
    input wire logic in_b,
    input wire logic in_reset,
    // Configuration
    input wire logic menu_active,
    input wire prs_pkg::prs_mode_t mode,
    input wire logic [14:0] reference_input_rate,
    input wire logic [19:0] display_setpoint,
    input wire logic [2:0] rate_point_pos,
    input wire logic [15:0] wait_seconds,
    input wire prs_pkg::prs_filt_t filter_sel,
    input wire prs_pkg::prs_fmt_t time_format,
    input wire prs_pkg::prs_base_t sw_base,
    input wire prs_pkg::prs_start_t sw_start_sel,
    input wire logic sw_auto_restart,
    input wire logic sw_latch,
    // Results
    output logic [31:0] display_value,
    output logic [2:0] decimal_pos,
    output logic result_strobe,
    output logic sw_running
);

    typedef struct packed {
        logic a_s1, a_s2, a_d, b_s1, b_s2, b_d, r_s1, r_s2;
        logic [15:0] r_cnt;
        logic [prs_pkg::PER_W-1:0] per_cnt;
        logic have_edge;
        logic [26:0] sec_pre;
        logic [15:0] sec_cnt;
        logic timed_out;
        logic div_busy;
        logic [5:0] div_cnt;
        logic [prs_pkg::DIV_W-1:0] div_rem, div_quo, div_den;
        logic [15:0][31:0] hist;
        logic [26:0] ms_pre;
        logic [12:0] unit_pre;
        logic [31:0] sw_count;
        logic sw_run;
        logic [31:0] disp;
        logic [2:0] dp;
        logic strobe;
    } prs_state_t;

    prs_state_t st, nx;
    logic a_rise, a_fall, b_rise, ext_clr, div_done, timeout_ev, sw_start, sw_stop;
    logic [31:0] q32, avg;

    function automatic logic [31:0] prs_render(input logic [31:0] v, input logic mmss);
        logic [31:0] mins;
        mins = v / 32'(prs_pkg::SEC_PER_MIN);
        if (mmss) begin
            return 32'(mins * 32'(prs_pkg::MMSS_SCALE) + (v % 32'(prs_pkg::SEC_PER_MIN)));
        end
        return v;
    endfunction : prs_render

    always_comb begin
        logic [prs_pkg::DIV_W-1:0] rem_sh, quo_sh, prod;
        logic [15:0][31:0] hist_n;
        logic [35:0] sum;
        logic [2:0] k;
        logic [14:0] ref_c;
        logic [prs_pkg::PER_W-1:0] per;
        logic [12:0] unit_len;
        rem_sh = '0;
        quo_sh = '0;
        prod = '0;
        hist_n = st.hist;
        sum = '0;
        k = 3'h0;
        ref_c = reference_input_rate;
        per = st.per_cnt + 1'b1;
        unit_len = prs_pkg::UNIT_MS_1MS;
        nx = st;
        nx.strobe = 1'b0;
        q32 = '0;
        avg = '0;
        div_done = 1'b0;
        timeout_ev = 1'b0;
        sw_start = 1'b0;
        sw_stop = 1'b0;
        // Synchronise the pins, then detect rising edges on the settled copy
        nx.a_s1 = in_a;
        nx.a_s2 = st.a_s1;
        nx.a_d = st.a_s2;
        nx.b_s1 = in_b;
        nx.b_s2 = st.b_s1;
        nx.b_d = st.b_s2;
        nx.r_s1 = in_reset;
        nx.r_s2 = st.r_s1;
        a_rise = st.a_s2 & ~st.a_d;
        a_fall = ~st.a_s2 & st.a_d;
        b_rise = st.b_s2 & ~st.b_d;
        // A short reset glitch is ignored; the source must hold it long enough
        if (!st.r_s2) begin
            nx.r_cnt = '0;
        end else if (st.r_cnt != 16'(RESET_MIN_CYCLES)) begin
            nx.r_cnt = st.r_cnt + 1'b1;
        end
        ext_clr = st.r_s2 && (st.r_cnt == 16'(RESET_MIN_CYCLES - 1)) && !menu_active;
        if (ref_c < 15'(prs_pkg::REF_MIN_HZ)) begin
            ref_c = 15'(prs_pkg::REF_MIN_HZ);
        end else if (ref_c > 15'(prs_pkg::REF_MAX_HZ)) begin
            ref_c = 15'(prs_pkg::REF_MAX_HZ);
        end
        unique case (filter_sel)
            prs_pkg::PRS_FILT_2: k = 3'h1;
            prs_pkg::PRS_FILT_4: k = 3'h2;
            prs_pkg::PRS_FILT_8: k = 3'h3;
            prs_pkg::PRS_FILT_16: k = 3'h4;
            default: k = 3'h0;
        endcase
        unique case (sw_base)
            prs_pkg::PRS_BASE_10MS: unit_len = prs_pkg::UNIT_MS_10MS;
            prs_pkg::PRS_BASE_100MS: unit_len = prs_pkg::UNIT_MS_100MS;
            prs_pkg::PRS_BASE_SEC: unit_len = prs_pkg::UNIT_MS_SEC;
            prs_pkg::PRS_BASE_CMIN: unit_len = prs_pkg::UNIT_MS_CMIN;
            prs_pkg::PRS_BASE_DMIN: unit_len = prs_pkg::UNIT_MS_DMIN;
            prs_pkg::PRS_BASE_MIN_SEC: unit_len = prs_pkg::UNIT_MS_SEC;
            default: unit_len = prs_pkg::UNIT_MS_1MS;
        endcase
        // Nothing below advances while the menu is open
        if (!menu_active) begin
            if (mode != prs_pkg::PRS_STOPWATCH) begin
                // Input B is not looked at in the rate modes
                if (st.per_cnt != '1) begin
                    nx.per_cnt = per;
                end
                if (st.div_busy) begin
                    rem_sh = {st.div_rem[prs_pkg::DIV_W-2:0], st.div_quo[prs_pkg::DIV_W-1]};
                    quo_sh = {st.div_quo[prs_pkg::DIV_W-2:0], 1'b0};
                    if (rem_sh >= st.div_den) begin
                        rem_sh = rem_sh - st.div_den;
                        quo_sh[0] = 1'b1;
                    end
                    nx.div_rem = rem_sh;
                    nx.div_quo = quo_sh;
                    nx.div_cnt = st.div_cnt + 1'b1;
                    div_done = (st.div_cnt == 6'(prs_pkg::DIV_STEPS - 1));
                end
                if (div_done) begin
                    nx.div_busy = 1'b0;
                    q32 = (|quo_sh[prs_pkg::DIV_W-1:32]) ? '1 : quo_sh[31:0];
                    hist_n = {st.hist[14:0], q32};
                    for (int i = 0; i < 16; i++) begin
                        if (i < (1 << k)) begin
                            sum = sum + 36'(hist_n[i]);
                        end
                    end
                    avg = 32'(sum >> k);
                    nx.hist = hist_n;
                    nx.strobe = 1'b1;
                    nx.disp = (mode == prs_pkg::PRS_PROC_TIME)
                        ? prs_render(avg, time_format == prs_pkg::PRS_FMT_MIN_SEC) : avg;
                end
                if (mode == prs_pkg::PRS_PROC_TIME) begin
                    nx.dp = (time_format == prs_pkg::PRS_FMT_MIN_SEC
                        || time_format == prs_pkg::PRS_FMT_CMIN) ? 3'h2 : 3'h0;
                end else begin
                    nx.dp = rate_point_pos;
                end
                if (a_rise) begin
                    nx.per_cnt = '0;
                    nx.have_edge = 1'b1;
                    nx.sec_pre = '0;
                    nx.sec_cnt = '0;
                    nx.timed_out = 1'b0;
                    // Period of 4000 cycles at the top rate leaves ample room for 64 steps
                    if (st.have_edge && !st.div_busy) begin
                        if (mode == prs_pkg::PRS_PROC_TIME) begin
                            prod = 64'(display_setpoint) * 64'(ref_c) * 64'(per);
                            nx.div_den = 64'(prs_pkg::CLK_HZ);
                        end else begin
                            prod = 64'(display_setpoint) * 64'(prs_pkg::CLK_HZ);
                            nx.div_den = 64'(per) * 64'(ref_c);
                        end
                        nx.div_quo = prod;
                        nx.div_rem = '0;
                        nx.div_cnt = '0;
                        nx.div_busy = 1'b1;
                    end
                end else if (!st.timed_out) begin
                    nx.sec_pre = st.sec_pre + 1'b1;
                    if (st.sec_pre == 27'(SEC_CYCLES - 1)) begin
                        nx.sec_pre = '0;
                        nx.sec_cnt = st.sec_cnt + 1'b1;
                        timeout_ev = (wait_seconds != '0)
                            && (st.sec_cnt + 1'b1 == wait_seconds);
                    end
                end
                if (timeout_ev) begin
                    nx.timed_out = 1'b1;
                    nx.disp = '0;
                    nx.hist = '0;
                    nx.have_edge = 1'b0;
                    nx.strobe = 1'b1;
                end
                nx.sw_run = 1'b0;
            end else begin
                unique case (sw_start_sel)
                    prs_pkg::PRS_GATED: begin
                        sw_start = a_rise;
                        sw_stop = a_fall;
                    end
                    prs_pkg::PRS_START_STOP: begin
                        sw_start = a_rise && !st.sw_run;
                        sw_stop = b_rise && st.sw_run;
                    end
                    default: begin
                        sw_start = a_rise;
                        sw_stop = a_rise && st.sw_run;
                    end
                endcase
                if (st.sw_run) begin
                    nx.ms_pre = st.ms_pre + 1'b1;
                    if (st.ms_pre == 27'(MS_CYCLES - 1)) begin
                        nx.ms_pre = '0;
                        nx.unit_pre = st.unit_pre + 1'b1;
                        if (st.unit_pre >= unit_len - 1'b1) begin
                            nx.unit_pre = '0;
                            nx.sw_count = st.sw_count + 1'b1;
                        end
                    end
                end
                if (sw_stop) begin
                    // With latch in start/stop the count keeps running unseen
                    if (!(sw_latch && sw_start_sel == prs_pkg::PRS_START_STOP)) begin
                        nx.sw_run = 1'b0;
                    end
                    if (sw_latch || sw_start_sel == prs_pkg::PRS_PERIOD_MEASURE) begin
                        nx.disp = prs_render(st.sw_count,
                            sw_base == prs_pkg::PRS_BASE_MIN_SEC);
                        nx.strobe = 1'b1;
                    end
                end
                if (sw_start) begin
                    nx.sw_run = 1'b1;
                    if (sw_auto_restart || sw_start_sel == prs_pkg::PRS_PERIOD_MEASURE) begin
                        nx.sw_count = '0;
                        nx.ms_pre = '0;
                        nx.unit_pre = '0;
                    end
                end
                if (!sw_latch && sw_start_sel != prs_pkg::PRS_PERIOD_MEASURE) begin
                    nx.disp = prs_render(st.sw_count, sw_base == prs_pkg::PRS_BASE_MIN_SEC);
                end
                unique case (sw_base)
                    prs_pkg::PRS_BASE_MS: nx.dp = 3'h3;
                    prs_pkg::PRS_BASE_10MS, prs_pkg::PRS_BASE_CMIN,
                    prs_pkg::PRS_BASE_MIN_SEC: nx.dp = 3'h2;
                    prs_pkg::PRS_BASE_100MS, prs_pkg::PRS_BASE_DMIN: nx.dp = 3'h1;
                    default: nx.dp = 3'h0;
                endcase
                nx.div_busy = 1'b0;
                nx.have_edge = 1'b0;
            end
            if (ext_clr) begin
                nx.sw_count = '0;
                nx.ms_pre = '0;
                nx.unit_pre = '0;
                if (mode == prs_pkg::PRS_STOPWATCH) begin
                    nx.disp = '0;
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= nx;
        end
    end

    assign display_value = st.disp;
    assign decimal_pos = st.dp;
    assign result_strobe = st.strobe;
    assign sw_running = st.sw_run;

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);

    chk_b_ignored: assert property ((mode != prs_pkg::PRS_STOPWATCH && !a_rise && !menu_active)
        |=> !$rose(st.div_busy)) else $error("divider started without an A edge");
    chk_div_length: assert property ($rose(st.div_busy) && !menu_active && mode != prs_pkg::PRS_STOPWATCH
        |-> st.div_busy[*8] ##1 (st.div_cnt == 6'h08)) else $error("divider step count wrong");
    chk_timeout_zero: assert property (timeout_ev |=> (st.disp == '0) && st.strobe && st.timed_out)
        else $error("timeout did not clear display");
    chk_wait_forever: assert property ((wait_seconds == '0) |-> !timeout_ev)
        else $error("timeout with zero wait time");
    chk_filter_off: assert property ((div_done && filter_sel == prs_pkg::PRS_FILT_OFF
        && mode == prs_pkg::PRS_RATE_DISPLAY_MODE) |=> st.disp == $past(q32))
        else $error("unfiltered rate differs from quotient");
    chk_menu_freeze: assert property (menu_active |=> $stable(st.sw_count) && $stable(st.disp)
        && $stable(st.per_cnt)) else $error("measurement moved during menu");
    chk_gated_hold: assert property ((mode == prs_pkg::PRS_STOPWATCH && sw_start_sel == prs_pkg::PRS_GATED
        && !st.a_s2 && !st.a_d && !ext_clr) |=> !st.sw_run) else $error("gated count ran with A low");
    chk_restart_clear: assert property ((mode == prs_pkg::PRS_STOPWATCH && sw_start && sw_auto_restart
        && !menu_active) |=> st.sw_count == '0 && st.sw_run) else $error("start did not clear count");
    chk_reset_clear: assert property (ext_clr |=> st.sw_count == '0)
        else $error("external reset did not clear total");
    chk_latch_hold: assert property ((mode == prs_pkg::PRS_STOPWATCH && sw_latch && !sw_stop && !ext_clr)
        |=> $stable(st.disp)) else $error("latched display changed without stop");

    cov_rate_result: cover property (div_done && mode == prs_pkg::PRS_RATE_DISPLAY_MODE);
    cov_timeout: cover property (timeout_ev);
    cov_period_update: cover property (sw_stop && sw_start_sel == prs_pkg::PRS_PERIOD_MEASURE);
    cov_latch_stop: cover property (sw_stop && sw_latch && sw_start_sel == prs_pkg::PRS_START_STOP);

endmodule : prs_core

// File: verif/prs_sensor_model.sv
// Sensor pulse source driving pins A, B and the external reset
`timescale 1ns/1ps
module prs_sensor_model #(
    parameter int RESET_HOLD = 20,
    parameter int MIN_PERIOD = 4000
) (
    // Clock
    input wire logic clock,
    // Sensor pins, push-pull so never left floating
    output logic in_a,
    output logic in_b,
    output logic in_reset
);
    logic [2:0] pins = 3'h0;
    assign in_a = pins[0];
    assign in_b = pins[1];
    assign in_reset = pins[2];

    // Active high pulse on pin 0 (A), 1 (B) or 2 (reset), launched after an edge
    task automatic pin_pulse(input int pin, input int hi);
        int len;
        len = hi;
        if (pin == 2 && len < RESET_HOLD) begin
            len = RESET_HOLD; // A shorter reset pulse would go unrecognised
        end
        @(posedge clock);
        #1 pins[pin] = 1'b1;
        repeat (len) @(posedge clock);
        #1 pins[pin] = 1'b0;
    endtask : pin_pulse

    // A pulses with rising edges exactly per cycles apart, never above 25 kHz
    task automatic a_train(input int n, input int per);
        int p;
        p = (per < MIN_PERIOD) ? MIN_PERIOD : per;
        repeat (n) begin
            pin_pulse(0, p / 2);
            repeat (p - p / 2 - 1) @(posedge clock);
        end
    endtask : a_train
endmodule : prs_sensor_model

// File: verif/prs_core_tb.sv
// Self-checking bench for the pulse rate and stopwatch core
`timescale 1ns/1ps
module prs_core_tb;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic in_a;
    logic in_b;
    logic in_reset;
    logic menu_active = 1'b0;
    prs_pkg::prs_mode_t mode = prs_pkg::PRS_RATE_DISPLAY_MODE;
    logic [14:0] reference_input_rate = 15'h61a8;
    logic [19:0] display_setpoint = 20'h00640;
    logic [2:0] rate_point_pos = 3'h4;
    logic [15:0] wait_seconds = 16'h0029;
    prs_pkg::prs_filt_t filter_sel = prs_pkg::PRS_FILT_OFF;
    prs_pkg::prs_fmt_t time_format = prs_pkg::PRS_FMT_SEC;
    prs_pkg::prs_base_t sw_base = prs_pkg::PRS_BASE_MS;
    prs_pkg::prs_start_t sw_start_sel = prs_pkg::PRS_START_STOP;
    logic sw_auto_restart = 1'b0;
    logic sw_latch = 1'b0;
    logic [31:0] display_value;
    logic [2:0] decimal_pos;
    logic result_strobe;
    logic sw_running;
    logic [31:0] vals[$];
    logic [31:0] prev;
    int mismatches = 0;
    int checks = 0;
    int n0;

    always #5 clock = ~clock;

    prs_core #(.RESET_MIN_CYCLES(20), .MS_CYCLES(10), .SEC_CYCLES(100)) prs_core_inst (
        .clock, .rst_b, .in_a, .in_b, .in_reset, .menu_active, .mode,
        .reference_input_rate, .display_setpoint, .rate_point_pos, .wait_seconds,
        .filter_sel, .time_format, .sw_base, .sw_start_sel, .sw_auto_restart,
        .sw_latch, .display_value, .decimal_pos, .result_strobe, .sw_running
    );

    prs_sensor_model #(.RESET_HOLD(30)) prs_sensor_model_inst (
        .clock, .in_a, .in_b, .in_reset
    );

    // Every announced result, in order; read on the clock edge, before the core updates
    always @(posedge clock) begin
        if (result_strobe === 1'b1) begin
            vals.push_back(display_value);
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp_v);
        checks++;
        if (seen !== exp_v) begin
            mismatches++;
            $display("unexpected %s: expected %0d seen %0d", what, exp_v, seen);
        end
    endtask : check

    // Counts carry a prescaler phase, so a window of up to five units is allowed
    task automatic in_range(input string what, input logic [31:0] seen, input int lo, input int hi);
        check(what, 32'(seen >= lo && seen <= hi), 32'h1);
    endtask : in_range

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : complete_run

    task automatic wait_strobe(input int limit);
        int n;
        n = vals.size();
        for (int i = 0; i < limit && vals.size() == n; i++) @(posedge clock);
        #1;
        if (vals.size() == n) begin
            mismatches++;
            $display("unexpected missing result after %0d cycles", limit);
            complete_run();
        end
    endtask : wait_strobe

    // Start on A, mid-run look at the display, stop on B
    task automatic sw_interval(input int gap, input int lo, input int hi);
        prs_sensor_model_inst.pin_pulse(0, 5);
        repeat (gap / 2 - 6) @(posedge clock);
        #1;
        in_range("running display", display_value, lo, hi);
        check("running flag", 32'(sw_running), 32'h1);
        repeat (gap - gap / 2) @(posedge clock);
        prs_sensor_model_inst.pin_pulse(1, 5);
        repeat (6) @(posedge clock);
        #1;
    endtask : sw_interval

    initial begin
        repeat (4) @(posedge clock);
        #1 rst_b = 1'b1;
        check("display after reset", display_value, 32'h0);
        // B pulses alongside A must not disturb the rate
        fork
            prs_sensor_model_inst.a_train(3, 4000);
            prs_sensor_model_inst.pin_pulse(1, 2000);
        join
        #1;
        check("rate results", 32'(vals.size()), 32'h2);
        check("rate value", vals[$], 32'h640);
        check("rate point", 32'(decimal_pos), 32'h4);
        wait_strobe(4000);
        check("timeout value", vals[$], 32'h0);
        for (int k = 1; k <= 2; k++) begin
            filter_sel = prs_pkg::prs_filt_t'(k);
            n0 = vals.size();
            prs_sensor_model_inst.a_train(2 ** k + 1, 4000);
            #1;
            check("filter first", vals[n0], 32'h640 >> k);
            check("filter settled", vals[$], 32'h640);
            wait_strobe(4000);
        end
        filter_sel = prs_pkg::PRS_FILT_OFF;
        wait_seconds = 16'h0000;
        n0 = vals.size();
        prs_sensor_model_inst.a_train(2, 4000);
        repeat (600) @(posedge clock);
        #1;
        check("held results", 32'(vals.size()), 32'(n0 + 1));
        check("held display", display_value, 32'h640);
        mode = prs_pkg::PRS_PROC_TIME;
        prs_sensor_model_inst.a_train(1, 4000);
        for (int f = 0; f < 4; f++) begin
            #1 time_format = prs_pkg::prs_fmt_t'(f);
            prs_sensor_model_inst.a_train(1, 4000);
            #1;
            check("time point", 32'(decimal_pos), f >= 2 ? 32'h2 : 32'h0);
            if (f % 2 == 0) begin
                check("time value", vals[$], f == 0 ? 32'h640 : 32'ha50);
            end
        end
        mode = prs_pkg::PRS_STOPWATCH;
        prs_sensor_model_inst.pin_pulse(2, 30);
        sw_interval(1000, 46, 51);
        in_range("interval", display_value, 98, 101);
        check("stopped flag", 32'(sw_running), 32'h0);
        sw_interval(500, 121, 126);
        in_range("accumulated", display_value, 147, 151);
        sw_auto_restart = 1'b1;
        sw_interval(300, 11, 16);
        in_range("restarted", display_value, 28, 31);
        menu_active = 1'b1;
        prs_sensor_model_inst.pin_pulse(0, 5);
        repeat (6) @(posedge clock);
        #1;
        check("menu flag", 32'(sw_running), 32'h0);
        menu_active = 1'b0;
        sw_start_sel = prs_pkg::PRS_GATED;
        sw_auto_restart = 1'b0;
        prs_sensor_model_inst.pin_pulse(2, 30);
        prs_sensor_model_inst.pin_pulse(0, 600);
        repeat (6) @(posedge clock);
        #1;
        in_range("gated", display_value, 58, 61);
        sw_start_sel = prs_pkg::PRS_START_STOP;
        sw_auto_restart = 1'b1;
        sw_latch = 1'b1;
        prev = display_value;
        sw_interval(200, int'(prev), int'(prev));
        in_range("latched", display_value, 18, 21);
        check("background flag", 32'(sw_running), 32'h1);
        prs_sensor_model_inst.pin_pulse(2, 30);
        repeat (10) @(posedge clock);
        #1;
        check("external clear", display_value, 32'h0);
        sw_latch = 1'b0;
        sw_start_sel = prs_pkg::PRS_PERIOD_MEASURE;
        prs_sensor_model_inst.a_train(1, 4000);
        #1;
        for (int b = 0; b < 3; b++) begin
            sw_base = prs_pkg::prs_base_t'(b);
            // The period in flight began under the old base, so it is skipped
            prs_sensor_model_inst.a_train(b > 0 ? 2 : 1, 4000);
            #1;
            in_range("period", vals[$], 400 / (10 ** b) - 1, 400 / (10 ** b));
            check("base point", 32'(decimal_pos), 32'(3 - b));
        end
        for (int b = 3; b < 7; b++) begin
            sw_base = prs_pkg::prs_base_t'(b);
            repeat (2) @(posedge clock);
            #1;
            check("base point", 32'(decimal_pos), b == 5 ? 32'h1 : (b == 3 ? 32'h0 : 32'h2));
        end
        complete_run();
    end
endmodule : prs_core_tb
